// [rtl/flash_port_pkg.sv]
// Types for the parallel flash timed port.
// Assumes flash_port_regs.svh supplies widths.
`include "flash_port_regs.svh"
package flash_port_pkg;
    typedef enum logic [1:0] {UNIT_NS, UNIT_US, UNIT_MS, UNIT_CYC} time_unit_t;
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT} port_state_t;
    typedef struct packed {
        logic select_n;
        logic read_n;
        logic write_n;
    } strobe_t;
endpackage : flash_port_pkg

// [rtl/flash_port_regs.svh]
// Timing and size constants for the parallel flash timed port.
// Assumes a 100 MHz system clock; intervals are fixed when the system is built.
`ifndef FLASH_PORT_REGS_SVH
`define FLASH_PORT_REGS_SVH

`define CLK_PERIOD_PS 10000
`define FLASH_ADDR_W 22
`define FLASH_DATA_W 16
`define BUS_DATA_W 32
`define SETUP_TIME_NS 30
`define WAIT_TIME_NS 90
`define HOLD_TIME_NS 20
`define SETUP_CYC ((`SETUP_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAIT_CYC ((`WAIT_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HOLD_CYC ((`HOLD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CNT_W 8

`endif

// [rtl/flash_timed_port.sv]
// Memory-mapped slave that reaches an external parallel flash over a shared pin bus.
// Assumes a single master request held until ack, and a bridge that resolves the
// shared data pins from the output enable.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - After chip-select goes active the port waits the setup interval before any strobe.
// - The read or write strobe stays active for the whole wait interval.
// - After the write strobe ends chip-select stays active for the hold interval.
// - Setup, wait and hold may be given in ns, us, ms or clock cycles at build time.
// - Setup should equal the flash select-to-output delay less its enable-to-output delay.
// - Setup plus wait plus board delay should exceed the flash address-to-output time.
// - Flash address and data widths fix the size of the address window the port takes.
// - Bus sizing lets a wider master reach the narrower flash correctly. The port sizes by 16-bit lane, so one enabled byte writes its whole half.
// - Any master reads the flash directly as memory, with no command sequence.
// - Address and data pins are shared, each chip having its own select and strobes.
// - The port is only a pin-bus slave for reads and writes shaped by the intervals.
module flash_timed_port
    import flash_port_pkg::*;
#(
    parameter int unsigned SETUP_AMOUNT = `SETUP_TIME_NS,
    parameter int unsigned WAIT_AMOUNT = `WAIT_TIME_NS,
    parameter int unsigned HOLD_AMOUNT = `HOLD_TIME_NS,
    parameter time_unit_t TIME_UNIT = UNIT_NS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [`FLASH_ADDR_W-1:0] bus_address,
    input wire logic [`BUS_DATA_W-1:0] bus_writedata,
    input wire logic [3:0] bus_byteenable,
    output logic bus_ack,
    output logic [`BUS_DATA_W-1:0] bus_readdata,
    output logic [`FLASH_ADDR_W-1:0] flash_addr,
    output logic [`FLASH_DATA_W-1:0] flash_data_out,
    output logic flash_data_oe,
    input wire logic [`FLASH_DATA_W-1:0] flash_data_in,
    output strobe_t flash_strobe
);
    localparam int HALVES = `BUS_DATA_W / `FLASH_DATA_W;

    logic [`CNT_W-1:0] setup_cyc;
    logic [`CNT_W-1:0] wait_cyc;
    logic [`CNT_W-1:0] hold_cyc;

    interval_cycles #(.AMOUNT(SETUP_AMOUNT), .UNIT(TIME_UNIT)) u_setup (.cycles(setup_cyc));
    interval_cycles #(.AMOUNT(WAIT_AMOUNT), .UNIT(TIME_UNIT)) u_wait (.cycles(wait_cyc));
    interval_cycles #(.AMOUNT(HOLD_AMOUNT), .UNIT(TIME_UNIT)) u_hold (.cycles(hold_cyc));

    port_state_t state_r;
    logic [`CNT_W-1:0] cnt_r;
    logic is_write_r;
    logic half_r;
    logic [`FLASH_DATA_W-1:0] low_half_r;

    function automatic logic lane_on(input logic [3:0] be, input logic h);
        lane_on = h ? |be[3:2] : |be[1:0];
    endfunction : lane_on

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; reads do both 16-bit lanes, writes one flash transfer per enabled lane, or one high-lane transfer when none is enabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 8'h00;
            is_write_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if ((bus_read || bus_write) && !bus_ack) begin
                        is_write_r <= bus_write;
                        // Reads fetch both halves; writes skip unenabled lanes, except that an all-zero byteenable still writes the high half
                        half_r <= bus_write && !lane_on(bus_byteenable, 1'b0);
                        cnt_r <= setup_cyc;
                        state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_r <= 8'h01) begin
                        cnt_r <= wait_cyc;
                        state_r <= ST_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ST_STROBE: begin
                    if (cnt_r <= 8'h01) begin
                        cnt_r <= hold_cyc;
                        state_r <= is_write_r ? ST_HOLD : ST_NEXT;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ST_HOLD: begin
                    if (cnt_r <= 8'h01) begin
                        state_r <= ST_NEXT;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                ST_NEXT: begin
                    if (!half_r && (!is_write_r || lane_on(bus_byteenable, 1'b1))) begin
                        half_r <= 1'b1;
                        cnt_r <= setup_cyc;
                        state_r <= ST_SETUP;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive; select spans setup, strobe and hold
    // own strobes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_strobe <= '{select_n: 1'b1, read_n: 1'b1, write_n: 1'b1};
            flash_addr <= '0;
            flash_data_out <= '0;
            flash_data_oe <= 1'b0;
        end else begin
            flash_strobe.select_n <= !((state_r == ST_SETUP) || (state_r == ST_STROBE) ||
                (state_r == ST_HOLD));
            // Strobes lag the state by one flop like select, so no interval is cut short
            flash_strobe.read_n <= !((state_r == ST_STROBE) && !is_write_r);
            flash_strobe.write_n <= !((state_r == ST_STROBE) && is_write_r);
            flash_addr <= {bus_address[`FLASH_ADDR_W-1:1], half_r};
            flash_data_out <= half_r ? bus_writedata[31:16] : bus_writedata[15:0];
            flash_data_oe <= is_write_r && (state_r != ST_IDLE) && (state_r != ST_NEXT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read capture at strobe end and answer to the master
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_half_r <= '0;
            bus_readdata <= '0;
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= 1'b0;
            if ((state_r == ST_NEXT) && !is_write_r) begin
                if (!half_r) begin
                    low_half_r <= flash_data_in;
                end else begin
                    bus_readdata <= {flash_data_in, low_half_r};
                end
            end
            if ((state_r == ST_NEXT) &&
                (half_r || (is_write_r && !lane_on(bus_byteenable, 1'b1)))) begin
                bus_ack <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // setup at least one cycle
    a_setup_before_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(flash_strobe.read_n) || $fell(flash_strobe.write_n) |->
            $past(!flash_strobe.select_n))
        else $error("Strobe asserted without preceding select");
    a_write_select_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(flash_strobe.write_n) |-> !flash_strobe.select_n)
        else $error("Select dropped with write strobe");
    a_strobe_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(!flash_strobe.read_n && !flash_strobe.write_n))
        else $error("Read and write strobes both active");
    a_strobe_needs_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!flash_strobe.read_n || !flash_strobe.write_n) |-> !flash_strobe.select_n)
        else $error("Strobe active without select");
    a_drive_on_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        !flash_strobe.write_n |-> flash_data_oe)
        else $error("Write strobe without data drive");
    a_no_drive_on_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        !flash_strobe.read_n |-> !flash_data_oe)
        else $error("Data driven during read");
    a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_ack |=> !bus_ack)
        else $error("Ack longer than one cycle");
    a_read_answers: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_IDLE) && bus_read && !bus_ack |-> ##[4:1000] bus_ack)
        else $error("Read not answered");
endmodule : flash_timed_port
`default_nettype wire

// [rtl/interval_cycles.sv]
// Converts a build-time interval in a chosen unit to whole clock cycles.
// Assumes a 100 MHz clock; rounds up so the interval is met up to 255 cycles, above which the 8-bit count wraps.
`timescale 1ns/10ps
`default_nettype none
module interval_cycles
    import flash_port_pkg::*;
#(
    parameter int unsigned AMOUNT = 1,
    parameter time_unit_t UNIT = UNIT_NS
) (
    output logic [`CNT_W-1:0] cycles
);
    localparam longint unsigned PS_PER_UNIT =
        (UNIT == UNIT_NS) ? 64'd1000 :
        (UNIT == UNIT_US) ? 64'd1000000 : 64'd1000000000;
    localparam longint unsigned RAW = (UNIT == UNIT_CYC) ? 64'(AMOUNT) :
        (64'(AMOUNT) * PS_PER_UNIT + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    localparam longint unsigned CYC = (RAW == 0) ? 64'd1 : RAW;
    assign cycles = CYC[`CNT_W-1:0];
endmodule : interval_cycles
`default_nettype wire

// [verification/flash_chip_model.sv]
// Behavioural parallel flash chip for the timed port bench.
// Assumes active-low strobes sampled on the system clock; no pull on data.
`timescale 1ns/10ps
`default_nettype none
`include "flash_port_regs.svh"
module flash_chip_model
    import flash_port_pkg::*;
#(
    parameter int ACC_CYC = 6
) (
    input wire logic core_clk,
    input wire strobe_t flash_strobe,
    input wire logic [`FLASH_ADDR_W-1:0] flash_addr,
    input wire logic [`FLASH_DATA_W-1:0] flash_data_out,
    input wire logic flash_data_oe,
    output logic [`FLASH_DATA_W-1:0] flash_data_in
);
    logic [15:0] mem [16];
    logic [15:0] junk_r = 16'hA5C3;
    int acc_r = 0;
    logic rd_ok;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h1000 + 16'(i);
        end
    end
    assign rd_ok = !flash_strobe.select_n && !flash_strobe.read_n && acc_r >= ACC_CYC;
    // Data is only valid after the access time; otherwise a changing pattern
    assign flash_data_in = rd_ok ? mem[flash_addr[3:0]] : junk_r;
    always @(posedge core_clk) begin
        acc_r <= (!flash_strobe.select_n && !flash_strobe.read_n) ? acc_r + 1 : 0;
        junk_r <= ~junk_r;
        if (!flash_strobe.select_n && !flash_strobe.write_n && flash_data_oe) begin
            mem[flash_addr[3:0]] <= flash_data_out;
        end
    end
endmodule : flash_chip_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the parallel flash timed port.
// Runs 25/85/11 ns intervals, which round up to 3/9/2 cycles at 100 MHz.
`timescale 1ns/10ps
`default_nettype none
`include "flash_port_regs.svh"
module testbench
    import flash_port_pkg::*;
;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic bus_read = 1'h0;
    logic bus_write = 1'h0;
    logic [21:0] bus_address = 22'h0;
    logic [31:0] bus_writedata = 32'h0;
    logic [3:0] bus_byteenable = 4'hF;
    logic bus_ack, flash_data_oe, lo_now, lo_was;
    logic [31:0] bus_readdata, rd;
    logic [21:0] flash_addr;
    logic [15:0] flash_data_out, flash_data_in;
    logic cc_ack, cc_oe;
    logic [31:0] cc_readdata;
    logic [21:0] cc_addr;
    logic [15:0] cc_data_out;
    logic [26:0] pins_ns, pins_cc;
    strobe_t flash_strobe, cc_strobe;
    strobe_t prv = 3'h7;
    int err_count = 0, cmp_count = 0, cyc = 0, su_n = 0, st_n = 0, ho_n = 0;
    int su_last = 0, st_last = 0, ho_last = 0;
    logic hold_on = 1'h0;
    always #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    flash_timed_port #(.SETUP_AMOUNT(25), .WAIT_AMOUNT(85), .HOLD_AMOUNT(11),
        .TIME_UNIT(UNIT_NS)) dut (.core_clk(core_clk), .rst_n(rst_n), .bus_read(bus_read),
        .bus_write(bus_write), .bus_address(bus_address), .bus_writedata(bus_writedata),
        .bus_byteenable(bus_byteenable), .bus_ack(bus_ack), .bus_readdata(bus_readdata),
        .flash_addr(flash_addr), .flash_data_out(flash_data_out),
        .flash_data_oe(flash_data_oe), .flash_data_in(flash_data_in),
        .flash_strobe(flash_strobe));
    flash_chip_model chip (.core_clk(core_clk), .flash_strobe(flash_strobe),
        .flash_addr(flash_addr), .flash_data_out(flash_data_out),
        .flash_data_oe(flash_data_oe), .flash_data_in(flash_data_in));
    // Same intervals given in clock cycles; its pins must match dut cycle for cycle
    flash_timed_port #(.SETUP_AMOUNT(3), .WAIT_AMOUNT(9), .HOLD_AMOUNT(2),
        .TIME_UNIT(UNIT_CYC)) dut_cyc (.core_clk(core_clk), .rst_n(rst_n),
        .bus_read(bus_read), .bus_write(bus_write), .bus_address(bus_address),
        .bus_writedata(bus_writedata), .bus_byteenable(bus_byteenable), .bus_ack(cc_ack),
        .bus_readdata(cc_readdata), .flash_addr(cc_addr), .flash_data_out(cc_data_out),
        .flash_data_oe(cc_oe), .flash_data_in(flash_data_in), .flash_strobe(cc_strobe));
    assign pins_ns = {flash_strobe, bus_ack, flash_data_oe, flash_addr};
    assign pins_cc = {cc_strobe, cc_ack, cc_oe, cc_addr};
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_eq
    // Reports the count itself when it falls short of the minimum
    task automatic chk_ge(input int got, input int lo);
        chk_eq(32'(got < lo ? got : lo), 32'(lo));
    endtask : chk_ge
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic bus_xfer(input logic wr, input logic [21:0] a, input logic [31:0] d,
                            input logic [3:0] be);
        int n;
        n = 0;
        bus_read <= ~wr;
        bus_write <= wr;
        bus_address <= a;
        bus_writedata <= d;
        bus_byteenable <= be;
        @(posedge core_clk);
        while (bus_ack !== 1'h1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        rd = bus_readdata;
        chk_eq(32'(n < 300), 32'h1);
        bus_read <= 1'h0;
        bus_write <= 1'h0;
        @(posedge core_clk);
    endtask : bus_xfer
    ////////////////////////////////////////////////////////////////////////////
    // 25, 85 and 11 ns at a 10 ns period round up to 3, 9 and 2 cycles
    task automatic s_units();
        chk_eq(32'(su_last), 32'h3);
        chk_eq(32'(st_last), 32'h9);
        chk_eq(32'(ho_last), 32'h2);
    endtask : s_units
    task automatic s_direct_read();
        bus_xfer(1'h0, 22'h3FFFF8, 32'h0, 4'hF);
        chk_eq(rd, 32'h10091008);
        bus_xfer(1'h0, 22'h3FFFFA, 32'h0, 4'hF);
        chk_eq(rd, 32'h100B100A);
    endtask : s_direct_read
    task automatic s_write_back();
        bus_xfer(1'h1, 22'h000004, 32'hCAFEBEEF, 4'hF);
        bus_xfer(1'h0, 22'h000004, 32'h0, 4'hF);
        chk_eq(rd, 32'hCAFEBEEF);
        bus_xfer(1'h1, 22'h000004, 32'h12345678, 4'hC);
        bus_xfer(1'h1, 22'h000004, 32'h5555AAAA, 4'h3);
        bus_xfer(1'h0, 22'h000004, 32'h0, 4'hF);
        chk_eq(rd, 32'h1234AAAA);
    endtask : s_write_back
    ////////////////////////////////////////////////////////////////////////////
    // Pin monitor: minimum counts only, the strobe edge alignment is a design choice
    always @(posedge core_clk) begin
        cyc++;
        lo_now = !(flash_strobe.read_n & flash_strobe.write_n);
        lo_was = !(prv.read_n & prv.write_n);
        if (rst_n) begin
            if (!flash_strobe.select_n && !lo_now && !hold_on) su_n++;
            if (lo_now && !lo_was) chk_ge(su_n, 3);
            if (lo_now && !lo_was) su_last = su_n;
            if (lo_now && !lo_was) st_n = 0;
            if (lo_now) st_n++;
            if (!lo_now && lo_was) chk_ge(st_n, 8);
            if (!lo_now && lo_was) st_last = st_n;
            if (!lo_now && lo_was) hold_on = !prv.write_n;
            if (!lo_now && lo_was) ho_n = 0;
            if (hold_on && !flash_strobe.select_n) ho_n++;
            if (flash_strobe.select_n && !prv.select_n && hold_on) chk_ge(ho_n, 2);
            if (flash_strobe.select_n && !prv.select_n && hold_on) ho_last = ho_n;
            chk_eq(32'(pins_cc), 32'(pins_ns));
            chk_eq({16'h0000, cc_data_out}, {16'h0000, flash_data_out});
            if (bus_ack) chk_eq(cc_readdata, bus_readdata);
            if (flash_strobe.select_n && !prv.select_n) hold_on = 1'h0;
            if (flash_strobe.select_n) su_n = 0;
            if (!flash_strobe.read_n) chk_eq(32'(flash_data_oe), 32'h0);
            if (!flash_strobe.write_n) chk_eq(32'(flash_data_oe), 32'h1);
            if (!flash_strobe.select_n && (bus_read || bus_write))
                chk_eq(32'(flash_addr[21:1]), 32'(bus_address[21:1]));
        end
        prv = flash_strobe;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        fork
            begin
                s_direct_read();
                s_write_back();
                s_units();
            end
            begin
                // Ceiling far above the roughly 200 cycles the transfers need
                while (cyc < 2000) begin
                    @(posedge core_clk);
                end
                err_count++;
            end
        join_any
        results();
    end
endmodule : testbench
`default_nettype wire
